/* File: verilog/spirl_pkg.sv */
// package: shared constants and carrier structs for the spi control block
package spirl_pkg;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic RST_MASTER_SELECT = 1'b1;
  localparam logic RST_CLOCK_PHASE = 1'b1;
  localparam logic RST_TX_EMPTY = 1'b1;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam int CLK_HZ = 25000000;
  localparam int HALF_DIV_MIN = 2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic receive_irq_enable;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic wired_or_mode;
    logic module_enable;
    logic transmit_irq_enable;
    logic error_irq_enable;
    logic select_fault_detect_enable;
    logic rate_select_high;
    logic rate_select_low;
  } spirl_ctrl_s;

  typedef struct packed {
    logic receive_full_flag;
    logic overrun_flag;
    logic select_fault_flag;
    logic transmit_empty_flag;
  } spirl_stat_s;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
    logic port_owns_sclk;
    logic port_owns_mosi;
    logic port_owns_miso;
    logic port_owns_ss;
  } spirl_pins_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b11
  } spirl_state_e;

endpackage

/* File: verilog/spirl_top.sv */
// spi control block: flags, resets, low power, break and pin ownership
module spirl_top
  import spirl_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CTRL_WR,
  input wire spirl_pkg::spirl_ctrl_s CTRL_IN,
  input wire logic STAT_RD,
  input wire logic DATA_RD,
  input wire logic DATA_WR,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic WAIT_MODE,
  input wire logic STOP_MODE,
  input wire logic BREAK_ACTIVE,
  input wire logic BREAK_CLEAR_ENABLE,
  input wire logic SCLK_I,
  input wire logic MOSI_I,
  input wire logic MISO_I,
  input wire logic SS_N_I,
  output spirl_pkg::spirl_ctrl_s CTRL_OUT,
  output spirl_pkg::spirl_stat_s STAT_OUT,
  output logic [DATA_W-1:0] DATA_OUT,
  output spirl_pkg::spirl_pins_s PINS,
  output logic RX_IRQ,
  output logic TX_IRQ,
  output logic WAKE_REQ
);
  import spirl_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] s1_q, s2_q, s3_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      // clock bit resets to its idle low so no false edge follows reset
      s1_q <= 4'h7;
      s2_q <= 4'h7;
      s3_q <= 4'h7;
    end
    else
    begin
      s1_q <= {SCLK_I, MOSI_I, MISO_I, SS_N_I};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic sclk_s, mosi_s, miso_s, ss_s, ss_fall, sclk_edge;
  assign sclk_s = s2_q[3];
  assign mosi_s = s2_q[2];
  assign miso_s = s2_q[1];
  assign ss_s = s2_q[0];
  assign ss_fall = s3_q[0] & ~ss_s;
  assign sclk_edge = s3_q[3] ^ sclk_s;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  spirl_ctrl_s ctrl_q, ctrl_d;
  spirl_stat_s stat_q, stat_d;
  spirl_state_e st_q, st_d;
  logic [DATA_W-1:0] shift_q, shift_d, rx_q, rx_d, tx_q, tx_d;
  logic [3:0] edges_q, edges_d;
  logic [7:0] div_q, div_d;
  logic sclk_q, sclk_d, tx_full_q, tx_full_d;
  logic rf_arm_q, rf_arm_d, mf_arm_q, mf_arm_d;

  logic active, master, slave_sel, mode_fault, lock;
  assign active = ctrl_q.module_enable & ~STOP_MODE;
  assign master = ctrl_q.master_select;
  assign slave_sel = active & ~master & ~ss_s;
  assign lock = BREAK_ACTIVE & ~BREAK_CLEAR_ENABLE;

  function automatic logic [7:0] half_div(input logic [1:0] r);
    unique case (r)
      2'b00: half_div = 8'h02;
      2'b01: half_div = 8'h08;
      2'b10: half_div = 8'h20;
      2'b11: half_div = 8'h80;
    endcase
  endfunction

  // fault: master sees select low, or selected slave deselected mid-byte
  assign mode_fault = active & ctrl_q.select_fault_detect_enable &
    (master ? ~ss_s : (ss_s & st_q != ST_IDLE));

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic done, start, cpu_ok, tick;
    done = 1'b0;
    tick = 1'b0;
    start = 1'b0;
    cpu_ok = ~WAIT_MODE;
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    st_d = st_q;
    shift_d = shift_q;
    rx_d = rx_q;
    tx_d = tx_q;
    edges_d = edges_q;
    div_d = div_q;
    sclk_d = sclk_q;
    tx_full_d = tx_full_q;
    rf_arm_d = rf_arm_q;
    mf_arm_d = mf_arm_q;
    if (cpu_ok && STAT_RD && !lock)
    begin
      rf_arm_d = stat_q.receive_full_flag | stat_q.overrun_flag;
      mf_arm_d = stat_q.select_fault_flag;
    end
    if (cpu_ok && CTRL_WR)
    begin
      ctrl_d = CTRL_IN;
      if (mf_arm_q && !lock && !mode_fault)
      begin
        stat_d.select_fault_flag = 1'b0;
        mf_arm_d = 1'b0;
      end
    end
    if (cpu_ok && DATA_RD && rf_arm_q && !lock)
    begin
      stat_d.receive_full_flag = 1'b0;
      stat_d.overrun_flag = 1'b0;
      rf_arm_d = 1'b0;
    end
    if (cpu_ok && DATA_WR && !lock)
    begin
      tx_d = DATA_IN;
      tx_full_d = 1'b1;
      stat_d.transmit_empty_flag = 1'b0;
    end
    if (!active)
    begin
      st_d = ST_IDLE;
      shift_d = '0;
      edges_d = '0;
      div_d = '0;
      sclk_d = ctrl_q.clock_polarity;
      if (!ctrl_q.module_enable)
      begin
        stat_d.transmit_empty_flag = 1'b1;
        tx_full_d = 1'b0;
      end
    end
    else
    begin
      if (st_q == ST_IDLE && tx_full_q &&
          (master || (ctrl_q.clock_phase && !ss_s) || ss_fall))
        start = 1'b1;
      if (start)
      begin
        shift_d = tx_q;
        tx_full_d = 1'b0;
        stat_d.transmit_empty_flag = 1'b1;
        st_d = ST_LEAD;
        edges_d = '0;
        div_d = '0;
      end
      else if (st_q != ST_IDLE)
      begin
        if (master)
        begin
          div_d = div_q + 8'h01;
          if (div_q + 8'h01 >= half_div({ctrl_q.rate_select_high,
                                          ctrl_q.rate_select_low}))
          begin
            div_d = '0;
            tick = 1'b1;
            sclk_d = ~sclk_q;
          end
        end
        else
          tick = sclk_edge & ~ss_s;
        if (tick)
        begin
          edges_d = edges_q + 4'h1;
          if (st_q == ST_LEAD)
          begin
            st_d = ST_TRAIL;
            shift_d = {shift_q[DATA_W-2:0], master ? miso_s : mosi_s};
          end
          else
            st_d = ST_LEAD;
          if (edges_q == 4'(2 * BITS_PER_BYTE - 1))
          begin
            st_d = ST_IDLE;
            done = 1'b1;
          end
        end
      end
      if (done)
      begin
        if (stat_q.receive_full_flag)
          stat_d.overrun_flag = 1'b1;
        else
        begin
          rx_d = shift_d;
          stat_d.receive_full_flag = 1'b1;
        end
      end
      if (mode_fault)
      begin
        stat_d.select_fault_flag = 1'b1;
        if (master)
        begin
          ctrl_d.module_enable = 1'b0;
          st_d = ST_IDLE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_q <= '{master_select: RST_MASTER_SELECT,
                 clock_phase: RST_CLOCK_PHASE, default: 1'b0};
      stat_q <= '{transmit_empty_flag: RST_TX_EMPTY, default: 1'b0};
      st_q <= ST_IDLE;
      shift_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      edges_q <= '0;
      div_q <= '0;
      sclk_q <= 1'b0;
      tx_full_q <= 1'b0;
      rf_arm_q <= 1'b0;
      mf_arm_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      st_q <= st_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      edges_q <= edges_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      tx_full_q <= tx_full_d;
      rf_arm_q <= rf_arm_d;
      mf_arm_q <= mf_arm_d;
    end
  end

  // ------------------------------------------------------------
  // outputs and pins
  // ------------------------------------------------------------
  assign CTRL_OUT = ctrl_q;
  assign STAT_OUT = stat_q;
  assign DATA_OUT = rx_q;
  assign RX_IRQ = (stat_q.receive_full_flag & ctrl_q.receive_irq_enable) |
    ((stat_q.overrun_flag | stat_q.select_fault_flag) &
     ctrl_q.error_irq_enable);
  assign TX_IRQ = stat_q.transmit_empty_flag &
    ctrl_q.transmit_irq_enable & ctrl_q.module_enable;
  assign WAKE_REQ = RX_IRQ | TX_IRQ;

  // msb of shifter drives the data line in both roles
  always_comb
  begin
    PINS.sclk_o = sclk_q;
    PINS.sclk_oe_n = ~(active & master);
    PINS.mosi_o = shift_q[DATA_W-1];
    PINS.mosi_oe_n = ~(active & master &
      (~ctrl_q.wired_or_mode | ~shift_q[DATA_W-1]));
    PINS.miso_o = shift_q[DATA_W-1];
    PINS.miso_oe_n = ~slave_sel;
    PINS.port_owns_sclk = ~active;
    PINS.port_owns_mosi = ~active;
    PINS.port_owns_miso = ~active;
    PINS.port_owns_ss = ~active |
      (master & ~ctrl_q.select_fault_detect_enable);
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence byte_done_s;
    st_q != ST_IDLE ##1 st_q == ST_IDLE && !stat_q.overrun_flag;
  endsequence

  rx_full_set_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (st_q != ST_IDLE && st_d == ST_IDLE && active && !mode_fault &&
     !stat_q.receive_full_flag && edges_q == 4'hF) |=>
    stat_q.receive_full_flag)
    else $error("receive full not set after byte");
  tx_empty_set_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (st_q == ST_IDLE && st_d == ST_LEAD && active) |=>
    stat_q.transmit_empty_flag && shift_q == $past(tx_q))
    else $error("transmit empty not set on load");
  disabled_idle_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !ctrl_q.module_enable |=> st_q == ST_IDLE && shift_q == '0 &&
    stat_q.transmit_empty_flag)
    else $error("disabled unit not idle");
  flags_kept_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    $fell(ctrl_q.module_enable) && !CTRL_WR |->
    stat_q.receive_full_flag == $past(stat_q.receive_full_flag))
    else $error("receive full changed on disable");
  fault_off_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    mode_fault && master |=> !ctrl_q.module_enable &&
    stat_q.select_fault_flag)
    else $error("master fault did not disable");
  break_freeze_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    lock && !mode_fault && st_q == ST_IDLE |=>
    stat_q.receive_full_flag == $past(stat_q.receive_full_flag))
    else $error("flag changed during break");
  break_write_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    lock && DATA_WR && !tx_full_q |=> !tx_full_q)
    else $error("data write took effect in break");
  miso_drive_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !PINS.miso_oe_n |-> !master && !ss_s && active)
    else $error("miso driven while not selected slave");
  mosi_od_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    ctrl_q.wired_or_mode && !PINS.mosi_oe_n |-> !PINS.mosi_o)
    else $error("mosi driven high in wired or mode");
  wake_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    WAIT_MODE && ((stat_q.receive_full_flag && ctrl_q.receive_irq_enable) ||
    (stat_q.transmit_empty_flag && ctrl_q.transmit_irq_enable &&
    ctrl_q.module_enable)) |-> WAKE_REQ)
    else $error("no wake on enabled irq");
  done_flag_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    byte_done_s |-> stat_q.receive_full_flag || !active ||
    stat_q.select_fault_flag)
    else $error("byte ended without receive full");

endmodule

/* File: dv/spirl_far_slave.sv */
// far-side slave model answering the master on the data-in line
module spirl_far_slave
(
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic [7:0] pattern,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr_q;
  initial miso = 1'b0;
  // msb is presented at select, so the first sampling edge finds it
  always @(negedge sel_n)
  begin
    sr_q = pattern;
    miso = pattern[7];
  end
  // seven falling edges move the rest of the byte out, one bit each
  always @(negedge sclk)
    if (!sel_n)
    begin
      sr_q = {sr_q[6:0], 1'b0};
      miso = sr_q[7];
    end
  // released line shows the inverse, never a stale level
  always @(posedge sel_n)
    miso = ~miso;
endmodule

/* File: dv/spirl_top_tb.sv */
// directed bench for the spi control block
module spirl_top_tb;
  import spirl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e, m) \
    begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %s", $time, m); end end
  localparam logic [7:0] FAR_BYTE = 8'hC6;
  logic sys_clk = 0, arst_n = 0, ctrl_wr = 0, stat_rd = 0, data_rd = 0;
  logic data_wr = 0, wait_mode = 0, stop_mode = 0, brk = 0, break_clear_enable = 0;
  logic sclk_i = 0, mosi_i = 0, ss_n_i = 1, psel_n = 1, miso_w;
  logic [7:0] data_in = 8'h00, rdata;
  logic rx_irq, tx_irq, wake;
  spirl_ctrl_s ctrl_in = '0, cfg, ctrl_out;
  spirl_stat_s stat;
  spirl_pins_s pins;
  int checks = 0, miscompares = 0, rises = 0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge pins.sclk_o) rises++;
  spirl_top #(.DATA_W(8)) u_spirl_top (
    .SYS_CLK(sys_clk), .ARST_N(arst_n), .CTRL_WR(ctrl_wr),
    .CTRL_IN(ctrl_in), .STAT_RD(stat_rd), .DATA_RD(data_rd),
    .DATA_WR(data_wr), .DATA_IN(data_in), .WAIT_MODE(wait_mode),
    .STOP_MODE(stop_mode), .BREAK_ACTIVE(brk),
    .BREAK_CLEAR_ENABLE(break_clear_enable), .SCLK_I(sclk_i), .MOSI_I(mosi_i),
    .MISO_I(miso_w), .SS_N_I(ss_n_i), .CTRL_OUT(ctrl_out),
    .STAT_OUT(stat), .DATA_OUT(rdata), .PINS(pins), .RX_IRQ(rx_irq),
    .TX_IRQ(tx_irq), .WAKE_REQ(wake));
  spirl_far_slave u_spirl_far_slave (.sclk(pins.sclk_o), .sel_n(psel_n),
    .pattern(FAR_BYTE), .miso(miso_w));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one strobe cycle, then a quiet cycle so strobes never merge
  task automatic op(logic cw, logic sr, logic dr, logic dw);
    ctrl_wr = cw; stat_rd = sr; data_rd = dr; data_wr = dw;
    tick(1);
    ctrl_wr = 0; stat_rd = 0; data_rd = 0; data_wr = 0;
    tick(1);
  endtask
  task automatic set_ctrl(spirl_ctrl_s c);
    ctrl_in = c;
    op(1, 0, 0, 0);
  endtask
  task automatic wait_rx();
    int n;
    for (n = 0; n < 4000 && stat.receive_full_flag !== 1'b1; n++)
      tick(1);
  endtask
  // link clock of 320 ns: data set on the leading edge
  task automatic slave_byte(logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_i = 1; mosi_i = b[i]; tick(4);
      sclk_i = 0; tick(4);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    #2000000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    cfg = '0; cfg.master_select = 1; cfg.clock_phase = 1;
    tick(4); arst_n = 1; tick(1);
    `CHK(ctrl_out, cfg, "control reset")
    `CHK(stat, 4'b0001, "flag reset")
    `CHK({pins.port_owns_sclk, pins.port_owns_mosi, pins.port_owns_miso,
      pins.port_owns_ss}, 4'hF, "pins owned by port")
    $display("test reset done");
    // phase zero on the master so the far byte is ready at select
    cfg.clock_phase = 0; cfg.module_enable = 1; cfg.rate_select_low = 1;
    cfg.receive_irq_enable = 1; cfg.transmit_irq_enable = 1;
    set_ctrl(cfg); psel_n = 0;
    `CHK(pins.sclk_oe_n, 1'b0, "clock out as master")
    `CHK(pins.miso_oe_n, 1'b1, "miso off as master")
    `CHK(pins.port_owns_ss, 1'b1, "select stays port")
    `CHK(tx_irq, 1'b1, "empty irq")
    rises = 0; data_in = 8'h5A; op(0, 0, 0, 1); tick(2);
    `CHK(stat.transmit_empty_flag, 1'b1, "empty after load")
    wait_rx();
    `CHK(rdata, FAR_BYTE, "master byte")
    `CHK(rx_irq, 1'b1, "full irq")
    `CHK(rises, 8, "eight clocks")
    psel_n = 1;
    `CHK({pins.mosi_o, pins.mosi_oe_n}, 2'b10, "mosi push pull")
    cfg.wired_or_mode = 1; set_ctrl(cfg);
    `CHK({pins.mosi_o, pins.mosi_oe_n}, 2'b11, "mosi released")
    cfg.wired_or_mode = 0;
    $display("test master done");
    cfg.module_enable = 0; set_ctrl(cfg);
    `CHK(ctrl_out, cfg, "controls kept")
    `CHK(stat.receive_full_flag, 1'b1, "full kept")
    `CHK(pins.port_owns_mosi, 1'b1, "disabled pins")
    ctrl_in = '0;
    wait_mode = 1; op(1, 0, 0, 0);
    `CHK(ctrl_out, cfg, "wait blocks access")
    `CHK(wake, 1'b1, "wake request")
    wait_mode = 0;
    $display("test disable done");
    cfg.module_enable = 1; set_ctrl(cfg);
    stop_mode = 1; tick(2);
    `CHK(pins.port_owns_mosi, 1'b1, "stop inactive")
    `CHK(ctrl_out, cfg, "stop keeps registers")
    stop_mode = 0;
    op(0, 1, 0, 0); brk = 1; data_in = 8'h11; op(0, 0, 0, 1);
    `CHK(stat.transmit_empty_flag, 1'b1, "break write ignored")
    op(0, 0, 1, 0);
    `CHK(stat.receive_full_flag, 1'b1, "break freezes")
    brk = 0; op(0, 0, 1, 0);
    `CHK(stat.receive_full_flag, 1'b0, "armed clear done")
    $display("test break done");
    ss_n_i = 0; tick(6);
    `CHK(ctrl_out.module_enable, 1'b1, "select ignored")
    ss_n_i = 1; tick(2);
    cfg.select_fault_detect_enable = 1; set_ctrl(cfg);
    `CHK(pins.port_owns_ss, 1'b0, "select is spi input")
    ss_n_i = 0; tick(6);
    `CHK(ctrl_out.module_enable, 1'b0, "fault disables")
    `CHK(stat.select_fault_flag, 1'b1, "fault flag")
    ss_n_i = 1; tick(4); brk = 1; break_clear_enable = 1; op(0, 1, 0, 0);
    cfg.select_fault_detect_enable = 0; cfg.module_enable = 0;
    set_ctrl(cfg); brk = 0; break_clear_enable = 0; tick(2);
    `CHK(stat.select_fault_flag, 1'b0, "break clear holds")
    $display("test fault done");
    cfg.master_select = 0; cfg.module_enable = 1; cfg.clock_phase = 1;
    set_ctrl(cfg);
    `CHK(pins.miso_oe_n, 1'b1, "deselected miso floats")
    `CHK(pins.port_owns_ss, 1'b0, "slave select input")
    data_in = 8'h96; op(0, 0, 0, 1); slave_byte(8'h3C); tick(6);
    `CHK(stat.receive_full_flag, 1'b0, "edges ignored")
    ss_n_i = 0; tick(4);
    `CHK(pins.miso_oe_n, 1'b0, "selected miso drives")
    slave_byte(8'hA7); tick(6);
    `CHK(stat.receive_full_flag, 1'b1, "slave byte in")
    `CHK(rdata, 8'hA7, "slave data")
    ss_n_i = 1;
    $display("test slave done");
    op(0, 1, 0, 0); op(0, 0, 1, 0);
    `CHK(stat.receive_full_flag, 1'b0, "full cleared")
    cfg.clock_phase = 0; set_ctrl(cfg);
    data_in = 8'hA5; op(0, 0, 0, 1); tick(4);
    `CHK(stat.transmit_empty_flag, 1'b0, "waits for select")
    ss_n_i = 0; tick(4);
    `CHK(stat.transmit_empty_flag, 1'b1, "select starts byte")
    `CHK(pins.miso_o, 1'b1, "msb out on select")
    slave_byte(8'h3C); tick(6); ss_n_i = 1; tick(4);
    `CHK(rdata, 8'h3C, "phase zero data")
    data_in = 8'h66; op(0, 0, 0, 1); ss_n_i = 0; tick(4);
    slave_byte(8'h81); tick(6);
    `CHK(stat.overrun_flag, 1'b1, "overrun on full")
    `CHK(rdata, 8'h3C, "old byte kept")
    ss_n_i = 1;
    $display("test phase zero done");
    stop_mode = 1; arst_n = 0; tick(2); stop_mode = 0; arst_n = 1; tick(1);
    cfg = '0; cfg.master_select = 1; cfg.clock_phase = 1;
    `CHK(ctrl_out, cfg, "reset out of stop")
    `CHK(stat, 4'b0001, "flags reset again")
    $display("test reset again done");
    give_verdict();
  end
endmodule
